// [rtl/cbu_cond.sv]
// Condition evaluator: one status-flag test per branch selector.
// Assumes flags and selector are stable, same-clock signals.
module cbu_cond
	import cbu_pkg::*;
(
	input  wire logic [COND_W-1:0] sel,
	input  wire logic              flag_z,
	input  wire logic              flag_c,
	input  wire logic              flag_n,
	input  wire logic              flag_v,
	input  wire logic              flag_h,
	output logic                   cond_true,
	output logic                   legal
);

	wire logic signed_lt;
	wire logic hit_ne;
	wire logic hit_cs;
	wire logic hit_cc;
	wire logic hit_mi;
	wire logic hit_pl;
	wire logic hit_ge;
	wire logic hit_lt;
	wire logic hit_hs;
	wire logic hit_hc;

	assign signed_lt = flag_n ^ flag_v;

	assign hit_ne = (sel == BR_NOT_EQUAL) && !flag_z;
	assign hit_cs = (sel == BR_CARRY_SET) && flag_c;
	assign hit_cc = (sel == BR_CARRY_CLEAR) && !flag_c;
	assign hit_mi = (sel == BR_NEGATIVE) && flag_n;
	assign hit_pl = (sel == BR_POSITIVE) && !flag_n;
	assign hit_ge = (sel == BR_GREATER_EQUAL_SIGNED) && !signed_lt;
	assign hit_lt = (sel == BR_LESS_SIGNED) && signed_lt;
	assign hit_hs = (sel == BR_HALF_CARRY_SET) && flag_h;
	assign hit_hc = (sel == BR_HALF_CARRY_CLEAR) && !flag_h;

	assign cond_true = hit_ne | hit_cs | hit_cc | hit_mi | hit_pl
		| hit_ge | hit_lt | hit_hs | hit_hc;

	// Unused selector codes never branch
	assign legal = (sel <= BR_HALF_CARRY_CLEAR);

endmodule

// [rtl/cbu_pkg.sv]
// Shared constants and types for the conditional branch unit.
// Assumes one core clock and a synchronous active-low core reset.
package cbu_pkg;

	// Condition selector, driven by the instruction decoder
	localparam int COND_W = 4;
	typedef enum logic [COND_W-1:0] {
		BR_NOT_EQUAL             = 4'h0,
		BR_CARRY_SET             = 4'h1,
		BR_CARRY_CLEAR           = 4'h2,
		BR_NEGATIVE              = 4'h3,
		BR_POSITIVE              = 4'h4,
		BR_GREATER_EQUAL_SIGNED  = 4'h5,
		BR_LESS_SIGNED           = 4'h6,
		BR_HALF_CARRY_SET        = 4'h7,
		BR_HALF_CARRY_CLEAR      = 4'h8
	} cbu_cond_t;

	// Aliases decode to the same condition as their base branch
	localparam cbu_cond_t BR_LOWER_UNSIGNED     = BR_CARRY_SET;
	localparam cbu_cond_t BR_SAME_OR_HIGHER     = BR_CARRY_CLEAR;

	// Sequencer states, one-hot
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h1,
		ST_TAKEN = 2'h2
	} cbu_state_t;

	// Default widths: word-addressed program counter, 7-bit offset
	localparam int PC_W_DEF  = 16;
	localparam int OFF_W_DEF = 7;

	// Cycles from the request to retirement
	localparam int CYC_NOT_TAKEN = 1;
	localparam int CYC_TAKEN     = 2;

	// Values after reset
	localparam logic RST_FLAG = 1'h0;

endpackage

// [rtl/cbu_top.sv]
// Conditional relative-branch unit: tests a flag, then retires the
// branch with the next program counter. Fed by the decoder on the core
// clock; the decoder holds further requests while BUSY is high.
module cbu_top
	import cbu_pkg::*;
#(
	parameter int PC_W  = PC_W_DEF,
	parameter int OFF_W = OFF_W_DEF
) (
	input  wire logic              CORE_CLK,
	input  wire logic              RST_N,
	input  wire logic              START,
	input  wire logic [COND_W-1:0] OPSEL,
	input  wire logic [OFF_W-1:0]  OFFSET,
	input  wire logic [PC_W-1:0]   PC_IN,
	input  wire logic              FLAG_Z,
	input  wire logic              FLAG_C,
	input  wire logic              FLAG_N,
	input  wire logic              FLAG_V,
	input  wire logic              FLAG_H,
	output logic [PC_W-1:0]        PC_NEXT,
	output logic                   PC_LOAD,
	output logic                   BUSY,
	output logic                   TAKEN,
	output logic                   BAD_OP,
	output logic                   SREG_WE
);

	////////////////////////////////////////////////////////////////////
	// Condition and target

	localparam logic [PC_W-1:0] PC_ONE = PC_W'(1);

	cbu_state_t        state_q;
	cbu_state_t        state_d;
	logic [PC_W-1:0]   target_q;
	logic [PC_W-1:0]   pc_next_q;
	logic              pc_load_q;
	logic              busy_q;
	logic              taken_q;
	logic              bad_op_q;
	logic              sreg_we_q;

	wire logic            cond_true;
	wire logic            legal;
	wire logic            go;
	wire logic            jump;
	wire logic [PC_W-1:0] off_ext;
	wire logic [PC_W-1:0] pc_fall;
	wire logic [PC_W-1:0] pc_jump;

	cbu_cond u_cond (
		.sel       (OPSEL),
		.flag_z    (FLAG_Z),
		.flag_c    (FLAG_C),
		.flag_n    (FLAG_N),
		.flag_v    (FLAG_V),
		.flag_h    (FLAG_H),
		.cond_true (cond_true),
		.legal     (legal)
	);

	// Requests during the second cycle of a taken branch are ignored
	assign go      = START && (state_q == ST_IDLE);
	assign jump    = go && legal && cond_true;
	assign off_ext = {{(PC_W-OFF_W){OFFSET[OFF_W-1]}}, OFFSET};
	assign pc_fall = PC_IN + PC_ONE;
	assign pc_jump = PC_IN + off_ext + PC_ONE;

	////////////////////////////////////////////////////////////////////
	// Sequencer

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (jump) begin
					state_d = ST_TAKEN;
				end
			end
			ST_TAKEN: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Target captured at the request so PC_IN may move during the stall
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			target_q <= '0;
		end else if (jump) begin
			target_q <= pc_jump;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Retirement outputs

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			pc_next_q <= '0;
			pc_load_q <= RST_FLAG;
			taken_q   <= RST_FLAG;
		end else if (state_q == ST_TAKEN) begin
			pc_next_q <= target_q;
			pc_load_q <= 1'b1;
			taken_q   <= 1'b1;
		end else if (go && !jump) begin
			pc_next_q <= pc_fall;
			pc_load_q <= 1'b1;
			taken_q   <= 1'b0;
		end else begin
			pc_load_q <= 1'b0;
			taken_q   <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			busy_q   <= RST_FLAG;
			bad_op_q <= RST_FLAG;
		end else begin
			busy_q   <= jump;
			bad_op_q <= go && !legal;
		end
	end

	// No path in this unit ever writes the status register
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			sreg_we_q <= RST_FLAG;
		end else begin
			sreg_we_q <= 1'b0;
		end
	end

	assign PC_NEXT = pc_next_q;
	assign PC_LOAD = pc_load_q;
	assign BUSY    = busy_q;
	assign TAKEN   = taken_q;
	assign BAD_OP  = bad_op_q;
	assign SREG_WE = sreg_we_q;

	////////////////////////////////////////////////////////////////////
	// Checks

	AST_NE: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		go && OPSEL == BR_NOT_EQUAL |=> BUSY == !$past(FLAG_Z))
		else $error("not-equal branch decision wrong");

	AST_CS: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		go && OPSEL == BR_CARRY_SET |=> BUSY == $past(FLAG_C))
		else $error("carry-set branch decision wrong");

	AST_CC: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		go && OPSEL == BR_CARRY_CLEAR |=> BUSY == !$past(FLAG_C))
		else $error("carry-clear branch decision wrong");

	AST_MI: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		go && OPSEL == BR_NEGATIVE |=> BUSY == $past(FLAG_N))
		else $error("negative branch decision wrong");

	AST_PL: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		go && OPSEL == BR_POSITIVE |=> BUSY == !$past(FLAG_N))
		else $error("positive branch decision wrong");

	AST_GE: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		go && OPSEL == BR_GREATER_EQUAL_SIGNED |=> BUSY == !$past(FLAG_N ^ FLAG_V))
		else $error("signed greater-equal branch decision wrong");

	AST_LT: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		go && OPSEL == BR_LESS_SIGNED |=> BUSY == $past(FLAG_N ^ FLAG_V))
		else $error("signed less-than branch decision wrong");

	AST_HS: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		go && OPSEL == BR_HALF_CARRY_SET |=> BUSY == $past(FLAG_H))
		else $error("half-carry-set branch decision wrong");

	AST_HC: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		go && OPSEL == BR_HALF_CARRY_CLEAR |=> BUSY == !$past(FLAG_H))
		else $error("half-carry-clear branch decision wrong");

	AST_NO_FLAGS: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		!SREG_WE)
		else $error("status write during a branch");

	AST_TWO_CYCLE: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		jump |=> BUSY && !PC_LOAD ##1 PC_LOAD && TAKEN && !BUSY)
		else $error("taken branch not retired in two cycles");

	AST_ONE_CYCLE: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		go && !jump |=> PC_LOAD && !TAKEN && PC_NEXT == PC_W'($past(PC_IN) + 1))
		else $error("fall-through not retired in one cycle");

	AST_TARGET: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
		jump |=> ##1 PC_NEXT == PC_W'($past(PC_IN, 2)
			+ PC_W'($signed($past(OFFSET, 2))) + 1))
		else $error("branch target is not PC plus offset plus one");

endmodule

// [sim/cbu_tb.sv]
// Self-checking bench for the conditional branch unit.
// Assumes cbu_pkg is compiled first; inputs change on falling edges.
module testbench
	import cbu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        core_clk;
	logic        rst_n;
	logic        start;
	logic [3:0]  opsel;
	logic [6:0]  offset;
	logic [15:0] pc_in;
	logic [4:0]  flags;
	logic [15:0] pc_next;
	logic        pc_load;
	logic        busy;
	logic        taken;
	logic        bad_op;
	logic        sreg_we;
	int          num_errors;
	int          cmp_count;

	cbu_top cbu_top_i (
		.CORE_CLK (core_clk),
		.RST_N    (rst_n),
		.START    (start),
		.OPSEL    (opsel),
		.OFFSET   (offset),
		.PC_IN    (pc_in),
		.FLAG_Z   (flags[4]),
		.FLAG_C   (flags[3]),
		.FLAG_N   (flags[2]),
		.FLAG_V   (flags[1]),
		.FLAG_H   (flags[0]),
		.PC_NEXT  (pc_next),
		.PC_LOAD  (pc_load),
		.BUSY     (busy),
		.TAKEN    (taken),
		.BAD_OP   (bad_op),
		.SREG_WE  (sreg_we)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic chk1(input logic a, input logic e);
		cmp_count++;
		if (a !== e) begin
			num_errors++;
			$display("BAD t=%0t got %h exp %h", $time, a, e);
		end
	endtask

	task automatic chk16(input logic [15:0] a, input logic [15:0] e);
		cmp_count++;
		if (a !== e) begin
			num_errors++;
			$display("BAD t=%0t got %h exp %h", $time, a, e);
		end
	endtask

	task automatic end_sim();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// One request; flags are {Z,C,N,V,H}; inputs scrambled after the edge
	task automatic br(input logic [3:0] sel, input logic [4:0] f, input logic tk,
		input logic [6:0] k = 7'h05, input logic [15:0] pc = 16'h1234);
		logic [15:0] exp;
		exp = tk ? pc + {{9{k[6]}}, k} + 16'h0001 : pc + 16'h0001;
		@(negedge core_clk);
		start = 1'b1;
		opsel = sel;
		flags = f;
		offset = k;
		pc_in = pc;
		@(negedge core_clk);
		start = 1'b0;
		pc_in = ~pc;
		flags = ~f;
		if (tk) begin
			chk1(busy, 1'b1);
			chk1(pc_load, 1'b0);
			@(negedge core_clk);
		end
		chk1(pc_load, 1'b1);
		chk1(busy, 1'b0);
		chk1(taken, tk);
		chk1(bad_op, sel > 4'h8);
		chk16(pc_next, exp);
		chk1(sreg_we, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_conditions();
		br(BR_NOT_EQUAL, 5'b00000, 1'b1);
		br(BR_NOT_EQUAL, 5'b10000, 1'b0);
		br(BR_CARRY_SET, 5'b01000, 1'b1);
		br(BR_LOWER_UNSIGNED, 5'b10111, 1'b0);
		br(BR_CARRY_CLEAR, 5'b10111, 1'b1);
		br(BR_SAME_OR_HIGHER, 5'b01000, 1'b0);
		br(BR_NEGATIVE, 5'b00100, 1'b1);
		br(BR_NEGATIVE, 5'b11011, 1'b0);
		br(BR_POSITIVE, 5'b11011, 1'b1);
		br(BR_POSITIVE, 5'b00100, 1'b0);
		br(BR_GREATER_EQUAL_SIGNED, 5'b00110, 1'b1);
		br(BR_GREATER_EQUAL_SIGNED, 5'b00010, 1'b0);
		br(BR_GREATER_EQUAL_SIGNED, 5'b00100, 1'b0);
		br(BR_LESS_SIGNED, 5'b00100, 1'b1);
		br(BR_LESS_SIGNED, 5'b00010, 1'b1);
		br(BR_LESS_SIGNED, 5'b00000, 1'b0);
		br(BR_HALF_CARRY_SET, 5'b00001, 1'b1);
		br(BR_HALF_CARRY_SET, 5'b11110, 1'b0);
		br(BR_HALF_CARRY_CLEAR, 5'b11110, 1'b1);
		br(BR_HALF_CARRY_CLEAR, 5'b00001, 1'b0);
	endtask

	task automatic t_offsets();
		br(BR_POSITIVE, 5'b00000, 1'b1, 7'h40, 16'h0010);
		br(BR_POSITIVE, 5'b00000, 1'b1, 7'h3f, 16'hffff);
		br(BR_NEGATIVE, 5'b00100, 1'b1, 7'h7f, 16'h0000);
	endtask

	task automatic t_illegal();
		for (int i = 9; i < 16; i++) begin
			br(i[3:0], 5'b11111, 1'b0);
		end
	endtask

	task automatic t_back_to_back();
		@(negedge core_clk);
		start = 1'b1;
		opsel = BR_NOT_EQUAL;
		flags = 5'b10000;
		offset = 7'h10;
		pc_in = 16'h0100;
		@(negedge core_clk);
		pc_in = 16'h0200;
		chk16(pc_next, 16'h0101);
		@(negedge core_clk);
		start = 1'b0;
		chk1(pc_load, 1'b1);
		chk16(pc_next, 16'h0201);
		@(negedge core_clk);
		chk1(pc_load, 1'b0);
	endtask

	// A request while busy must vanish without a load
	task automatic t_busy_ignore();
		@(negedge core_clk);
		start = 1'b1;
		opsel = BR_CARRY_SET;
		flags = 5'b01000;
		offset = 7'h7e;
		pc_in = 16'h0300;
		@(negedge core_clk);
		chk1(busy, 1'b1);
		opsel = BR_NOT_EQUAL;
		flags = 5'b00000;
		pc_in = 16'h0400;
		@(negedge core_clk);
		start = 1'b0;
		chk1(taken, 1'b1);
		chk16(pc_next, 16'h02ff);
		@(negedge core_clk);
		chk1(pc_load, 1'b0);
		chk1(busy, 1'b0);
	endtask

	task automatic t_reset_mid();
		@(negedge core_clk);
		start = 1'b1;
		opsel = BR_POSITIVE;
		flags = 5'b00000;
		pc_in = 16'h0500;
		@(negedge core_clk);
		start = 1'b0;
		rst_n = 1'b0;
		@(negedge core_clk);
		rst_n = 1'b1;
		chk1(pc_load, 1'b0);
		chk16(pc_next, 16'h0000);
		@(negedge core_clk);
		chk1(busy, 1'b0);
		chk1(pc_load, 1'b0);
		chk1(taken, 1'b0);
		br(BR_NOT_EQUAL, 5'b00000, 1'b1);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// Whole run is under a hundred cycles
	initial begin
		#40000;
		num_errors++;
		end_sim();
	end

	initial begin
		num_errors = 0;
		cmp_count = 0;
		rst_n = 1'b0;
		start = 1'b0;
		opsel = 4'h0;
		offset = 7'h00;
		pc_in = 16'h0000;
		flags = 5'b00000;
		repeat (3) @(negedge core_clk);
		rst_n = 1'b1;
		t_conditions();
		t_offsets();
		t_illegal();
		t_back_to_back();
		t_busy_ignore();
		t_reset_mid();
		end_sim();
	end
endmodule
